/* File: hdl/fpcd_pkg.sv */
// Constants, register map and command encodings of the protection controller
package fpcd_pkg;

    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;

    // APB register offsets
    localparam logic [7:0] CMD_OFS    = 8'h00;
    localparam logic [7:0] ADDR_OFS   = 8'h04;
    localparam logic [7:0] WDATA_OFS  = 8'h08;
    localparam logic [7:0] PWDLO_OFS  = 8'h0C;
    localparam logic [7:0] PWDHI_OFS  = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;
    localparam logic [7:0] RDATA_OFS  = 8'h18;
    localparam logic [7:0] CFG_OFS    = 8'h1C;

    // Field positions and reset values
    localparam int STAT_BUSY    = 0;
    localparam int STAT_REFUSED = 1;
    localparam int STAT_SET_LSB = 4;
    localparam int CFG_X16      = 0;
    localparam logic [31:0] PWD_RST = 32'hFFFFFFFF;

    // Flash bus command bytes
    localparam logic [7:0] UNL1_DATA   = 8'hAA;
    localparam logic [7:0] UNL2_DATA   = 8'h55;
    localparam logic [7:0] CODE_LOCKREG = 8'h40;
    localparam logic [7:0] CODE_PWD     = 8'h60;
    localparam logic [7:0] CODE_NV      = 8'hC0;
    localparam logic [7:0] CODE_LOCKBIT = 8'h50;
    localparam logic [7:0] CODE_VOL     = 8'hE0;
    localparam logic [7:0] CODE_EXTBLK  = 8'h88;
    localparam logic [7:0] CODE_EXIT    = 8'h90;
    localparam logic [7:0] CODE_ZERO    = 8'h00;
    localparam logic [7:0] CODE_ONE     = 8'h01;
    localparam logic [7:0] CODE_PROG    = 8'hA0;
    localparam logic [7:0] CODE_ERASE   = 8'h80;
    localparam logic [7:0] CODE_CONFIRM = 8'h30;
    localparam logic [7:0] CODE_UNLK1   = 8'h25;
    localparam logic [7:0] CODE_UNLK2   = 8'h03;
    localparam logic [7:0] CODE_UNLK3   = 8'h29;

    // Unlock addresses per bus width
    localparam logic [ADDR_W-1:0] UNL1_X8  = 24'h000AAA;
    localparam logic [ADDR_W-1:0] UNL2_X8  = 24'h000555;
    localparam logic [ADDR_W-1:0] UNL1_X16 = 24'h000555;
    localparam logic [ADDR_W-1:0] UNL2_X16 = 24'h0002AA;

    // Password portions per width
    localparam logic [3:0] PWD_PARTS_X8  = 4'h8;
    localparam logic [3:0] PWD_PARTS_X16 = 4'h4;

    // Timing
    localparam int CLK_NS        = 10;
    localparam int UNLOCK_GAP_NS = 1000;
    localparam int UNLOCK_GAP_CYC = (UNLOCK_GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_CYC = 2;
    localparam int PULSE_CYC = 8;
    localparam int RECOV_CYC = 2;

    typedef enum logic [3:0] {
        OP_ENTER_LOCKREG = 4'h0,
        OP_ENTER_PWD     = 4'h1,
        OP_ENTER_NV      = 4'h2,
        OP_ENTER_LOCKBIT = 4'h3,
        OP_ENTER_VOL     = 4'h4,
        OP_ENTER_EXTBLK  = 4'h5,
        OP_EXIT_PROT     = 4'h6,
        OP_EXIT_EXTBLK   = 4'h7,
        OP_PROG_LOCKREG  = 4'h8,
        OP_PROG_PWD      = 4'h9,
        OP_READ          = 4'hA,
        OP_PROG_BIT      = 4'hB,
        OP_CLR_VOLBIT    = 4'hC,
        OP_CLR_ALL_NV    = 4'hD,
        OP_PROG_LOCKBIT  = 4'hE,
        OP_UNLOCK_PWD    = 4'hF
    } fpcd_op_type;

    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_WAIT = 2'b01,
        SQ_RUN  = 2'b10
    } fpcd_seq_type;

    typedef enum logic [1:0] {
        EN_IDLE  = 2'b00,
        EN_SETUP = 2'b01,
        EN_PULSE = 2'b10,
        EN_RECOV = 2'b11
    } fpcd_eng_type;

endpackage

/* File: hdl/fpcd_cycle_if.sv */
// Request and answer of one flash bus cycle between sequencer and engine
`timescale 1ns/100ps
interface fpcd_cycle_if;
    logic                           req;
    logic                           isRead;
    logic [fpcd_pkg::ADDR_W-1:0]    addr;
    logic [fpcd_pkg::DATA_W-1:0]    wdata;
    logic                           done;
    logic [fpcd_pkg::DATA_W-1:0]    rdata;

    modport master (output req, output isRead, output addr, output wdata,
                    input done, input rdata);
    modport engine (input req, input isRead, input addr, input wdata,
                    output done, output rdata);
endinterface

/* File: hdl/fpcd_bus_cycle.sv */
// Engine that runs one chip-enable framed read or write cycle on the pins
`timescale 1ns/100ps
module fpcd_bus_cycle #(
    parameter int SETUP_CYC = fpcd_pkg::SETUP_CYC,
    parameter int PULSE_CYC = fpcd_pkg::PULSE_CYC,
    parameter int RECOV_CYC = fpcd_pkg::RECOV_CYC
) (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    fpcd_cycle_if.engine                       cyc,
    output logic [fpcd_pkg::ADDR_W-1:0]        flashAddr,
    output logic                               flashCeN,
    output logic                               flashOeN,
    output logic                               flashWeN,
    output logic [fpcd_pkg::DATA_W-1:0]        flashDqOut,
    output logic                               flashDqOe,
    input  wire logic [fpcd_pkg::DATA_W-1:0]   flashDqIn
);

    localparam logic [3:0] SETUP_LD = 4'(SETUP_CYC - 1);
    localparam logic [3:0] PULSE_LD = 4'(PULSE_CYC - 1);
    localparam logic [3:0] RECOV_LD = 4'(RECOV_CYC - 1);

    fpcd_pkg::fpcd_eng_type        state;
    logic [3:0]                    cnt;
    logic                          isRd;
    logic [fpcd_pkg::DATA_W-1:0]   dqMeta;
    logic [fpcd_pkg::DATA_W-1:0]   dqSync;

    assign cyc.done = (state == fpcd_pkg::EN_RECOV) && (cnt == 4'h0);

    ////////////////////////////////////////////////////////////////////////
    // Data pins come from the flash, outside this clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dqMeta <= '0;
            dqSync <= '0;
        end else begin
            dqMeta <= flashDqIn;
            dqSync <= dqMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= fpcd_pkg::EN_IDLE;
            cnt   <= 4'h0;
            isRd  <= 1'b0;
        end else begin
            case (state)
                fpcd_pkg::EN_IDLE: begin
                    if (cyc.req) begin
                        isRd  <= cyc.isRead;
                        cnt   <= SETUP_LD;
                        state <= fpcd_pkg::EN_SETUP;
                    end
                end
                fpcd_pkg::EN_SETUP: begin
                    cnt <= cnt - 4'h1;
                    if (cnt == 4'h0) begin
                        cnt   <= PULSE_LD;
                        state <= fpcd_pkg::EN_PULSE;
                    end
                end
                fpcd_pkg::EN_PULSE: begin
                    cnt <= cnt - 4'h1;
                    if (cnt == 4'h0) begin
                        cnt   <= RECOV_LD;
                        state <= fpcd_pkg::EN_RECOV;
                    end
                end
                fpcd_pkg::EN_RECOV: begin
                    cnt <= cnt - 4'h1;
                    if (cnt == 4'h0) begin
                        state <= fpcd_pkg::EN_IDLE;
                    end
                end
                default: begin
                    state <= fpcd_pkg::EN_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address and write data stay put for the whole frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flashAddr  <= '0;
            flashCeN   <= 1'b1;
            flashOeN   <= 1'b1;
            flashWeN   <= 1'b1;
            flashDqOut <= '0;
            flashDqOe  <= 1'b0;
        end else begin
            if (state == fpcd_pkg::EN_IDLE && cyc.req) begin
                flashAddr  <= cyc.addr;
                flashDqOut <= cyc.wdata;
                flashCeN   <= 1'b0;
                flashDqOe  <= !cyc.isRead;
            end
            if (state == fpcd_pkg::EN_SETUP && cnt == 4'h0) begin
                flashWeN <= isRd;
                flashOeN <= !isRd;
            end
            if (state == fpcd_pkg::EN_PULSE && cnt == 4'h0) begin
                flashWeN <= 1'b1;
                flashOeN <= 1'b1;
            end
            if (cyc.done) begin
                flashCeN  <= 1'b1;
                flashDqOe <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pulse must outlast the two synchroniser stages plus access time
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc.rdata <= '0;
        end else if (state == fpcd_pkg::EN_PULSE && cnt == 4'h0 && isRd) begin
            cyc.rdata <= dqSync;
        end
    end

endmodule

/* File: hdl/fpcd_host.sv */
// Host controller issuing flash block protection command sequences
//
// Contract
// R1 - Enter sets with three-cycle unlock prefix; code sends a two-cycle AA/55 prefix, then the set code
// R2 - Device blocks block 0 inside set
// R3 - Leave set with X/90 then X/00
// R4 - Upper data, high address ignored in commands
// R5 - Register reads are plain read cycles
// R6 - Read commands use bus read cycles
// R7 - Lock register: X/A0 then X/value
// R8 - Password: X/A0 then address/portion
// R9 - Password portions in any order
// R10 - Password read one byte per cycle
// R11 - Block bit: 00 sets, 01 clears
// R12 - Lock bit: X/A0 then X/00
// R13 - Unlock password: 11 cycles x8, 7 x16
// R14 - At least 1us between unlock commands
// R15 - Protected 00, unprotected 01
// R16 - Clear-all fails while lock bit is 0
// R17 - Clear-all 80/30; exit extended with prefix
`timescale 1ns/100ps
module fpcd_host (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [7:0]                    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic [31:0]                        prdata,
    output logic                               pready,
    output logic                               pslverr,
    output logic [fpcd_pkg::ADDR_W-1:0]        flashAddr,
    output logic                               flashCeN,
    output logic                               flashOeN,
    output logic                               flashWeN,
    output logic [fpcd_pkg::DATA_W-1:0]        flashDqOut,
    output logic                               flashDqOe,
    input  wire logic [fpcd_pkg::DATA_W-1:0]   flashDqIn
);

    fpcd_cycle_if cyc ();

    fpcd_pkg::fpcd_op_type         op;
    fpcd_pkg::fpcd_seq_type        state;
    logic [3:0]                    step;
    logic [fpcd_pkg::ADDR_W-1:0]   cmdAddr;
    logic [fpcd_pkg::DATA_W-1:0]   cmdData;
    logic [63:0]                   password;
    logic [fpcd_pkg::DATA_W-1:0]   readData;
    logic                          x16;
    logic                          refused;
    logic [2:0]                    activeSet;
    logic [6:0]                    gapCnt;
    logic                          wrEn;
    logic                          cmdWrite;
    logic                          mapped;
    logic                          isUnlock;
    logic                          stRead;
    logic                          stLast;
    logic [fpcd_pkg::ADDR_W-1:0]   stAddr;
    logic [fpcd_pkg::DATA_W-1:0]   stData;
    logic [fpcd_pkg::ADDR_W-1:0]   unl1;
    logic [fpcd_pkg::ADDR_W-1:0]   unl2;
    logic [7:0]                    setCode;
    logic [3:0]                    pwdParts;
    logic [2:0]                    pwdIdx;

    localparam logic [6:0] GAP_LD = 7'(fpcd_pkg::UNLOCK_GAP_CYC);

    ////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    assign pready   = 1'b1;
    assign wrEn     = psel && penable && pwrite;
    assign cmdWrite = wrEn && paddr == fpcd_pkg::CMD_OFS;
    assign isUnlock = op == fpcd_pkg::OP_UNLOCK_PWD;

    always_comb begin
        mapped = 1'b1;
        prdata = 32'h00000000;
        case (paddr)
            fpcd_pkg::CMD_OFS:    prdata = {28'h0000000, op};
            fpcd_pkg::ADDR_OFS:   prdata = 32'(cmdAddr);
            fpcd_pkg::WDATA_OFS:  prdata = 32'(cmdData);
            fpcd_pkg::PWDLO_OFS:  prdata = password[31:0];
            fpcd_pkg::PWDHI_OFS:  prdata = password[63:32];
            fpcd_pkg::STATUS_OFS: begin
                prdata[fpcd_pkg::STAT_BUSY]    = state != fpcd_pkg::SQ_IDLE;
                prdata[fpcd_pkg::STAT_REFUSED] = refused;
                prdata[fpcd_pkg::STAT_SET_LSB +: 3] = activeSet;
            end
            fpcd_pkg::RDATA_OFS:  prdata = 32'(readData);
            fpcd_pkg::CFG_OFS:    prdata[fpcd_pkg::CFG_X16] = x16;
            default:              mapped = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmdAddr  <= '0;
            cmdData  <= '0;
            password <= {fpcd_pkg::PWD_RST, fpcd_pkg::PWD_RST};
            x16      <= 1'b0;
        end else if (wrEn) begin
            case (paddr)
                fpcd_pkg::ADDR_OFS:  cmdAddr <= pwdata[fpcd_pkg::ADDR_W-1:0];
                fpcd_pkg::WDATA_OFS: cmdData <= pwdata[fpcd_pkg::DATA_W-1:0];
                fpcd_pkg::PWDLO_OFS: password[31:0] <= pwdata;
                fpcd_pkg::PWDHI_OFS: password[63:32] <= pwdata;
                fpcd_pkg::CFG_OFS:   x16 <= pwdata[fpcd_pkg::CFG_X16];
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Refused flag: a new refusal in the clearing cycle still sticks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            refused <= 1'b0;
        end else if (cmdWrite && state != fpcd_pkg::SQ_IDLE) begin
            refused <= 1'b1;
        end else if (wrEn && paddr == fpcd_pkg::STATUS_OFS
                     && pwdata[fpcd_pkg::STAT_REFUSED]) begin
            refused <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer; a command write while busy is dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= fpcd_pkg::SQ_IDLE;
            op    <= fpcd_pkg::OP_EXIT_PROT;
            step  <= 4'h0;
        end else begin
            case (state)
                fpcd_pkg::SQ_IDLE: begin
                    if (cmdWrite) begin
                        op    <= fpcd_pkg::fpcd_op_type'(pwdata[3:0]);
                        step  <= 4'h0;
                        state <= fpcd_pkg::SQ_WAIT;
                    end
                end
                fpcd_pkg::SQ_WAIT: begin
                    // Spacing enforced here so the flash never drops one
                    if (!isUnlock || gapCnt == 7'h00) begin // see R14
                        state <= fpcd_pkg::SQ_RUN;
                    end
                end
                fpcd_pkg::SQ_RUN: begin
                    if (cyc.done) begin
                        step <= step + 4'h1;
                        if (stLast) begin
                            state <= fpcd_pkg::SQ_IDLE;
                        end
                    end
                end
                default: begin
                    state <= fpcd_pkg::SQ_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gap timer restarts when an unlock sequence finishes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gapCnt <= 7'h00;
        end else if (state == fpcd_pkg::SQ_RUN && cyc.done && stLast
                     && isUnlock) begin
            gapCnt <= GAP_LD; // see R14
        end else if (gapCnt != 7'h00) begin
            gapCnt <= gapCnt - 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Track which set the flash sits in; 0 means read mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            activeSet <= 3'h0;
        end else if (state == fpcd_pkg::SQ_RUN && cyc.done && stLast) begin
            if (op <= fpcd_pkg::OP_ENTER_EXTBLK) begin
                activeSet <= 3'(op) + 3'h1;
            end else if (op == fpcd_pkg::OP_EXIT_PROT
                         || op == fpcd_pkg::OP_EXIT_EXTBLK) begin
                activeSet <= 3'h0; // see R3
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readData <= '0;
        end else if (state == fpcd_pkg::SQ_RUN && cyc.done && stRead) begin
            readData <= cyc.rdata; // see R5
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cycle table for the current operation and step
    always_comb begin
        unl1 = x16 ? fpcd_pkg::UNL1_X16 : fpcd_pkg::UNL1_X8; // see R1
        unl2 = x16 ? fpcd_pkg::UNL2_X16 : fpcd_pkg::UNL2_X8;
        pwdParts = x16 ? fpcd_pkg::PWD_PARTS_X16 : fpcd_pkg::PWD_PARTS_X8;
        pwdIdx = 3'(step - 4'h2);
        case (op)
            fpcd_pkg::OP_ENTER_LOCKREG: setCode = fpcd_pkg::CODE_LOCKREG;
            fpcd_pkg::OP_ENTER_PWD:     setCode = fpcd_pkg::CODE_PWD;
            fpcd_pkg::OP_ENTER_NV:      setCode = fpcd_pkg::CODE_NV;
            fpcd_pkg::OP_ENTER_LOCKBIT: setCode = fpcd_pkg::CODE_LOCKBIT;
            fpcd_pkg::OP_ENTER_VOL:     setCode = fpcd_pkg::CODE_VOL;
            fpcd_pkg::OP_ENTER_EXTBLK:  setCode = fpcd_pkg::CODE_EXTBLK;
            default:                    setCode = fpcd_pkg::CODE_EXIT;
        endcase
        stRead = 1'b0;
        stLast = step == 4'h1;
        // Command cycles drive zero on upper data and unused address
        stAddr = '0; // see R4
        stData = '0;
        case (op)
            fpcd_pkg::OP_ENTER_LOCKREG, fpcd_pkg::OP_ENTER_PWD,
            fpcd_pkg::OP_ENTER_NV, fpcd_pkg::OP_ENTER_LOCKBIT,
            fpcd_pkg::OP_ENTER_VOL, fpcd_pkg::OP_ENTER_EXTBLK,
            fpcd_pkg::OP_EXIT_EXTBLK: begin
                stLast = step == ((op == fpcd_pkg::OP_EXIT_EXTBLK)
                                  ? 4'h3 : 4'h2); // see R17
                case (step)
                    4'h0: begin
                        stAddr = unl1;
                        stData = 16'(fpcd_pkg::UNL1_DATA); // see R1
                    end
                    4'h1: begin
                        stAddr = unl2;
                        stData = 16'(fpcd_pkg::UNL2_DATA);
                    end
                    4'h2: begin
                        stAddr = unl1;
                        stData = 16'(setCode);
                    end
                    default: stData = 16'(fpcd_pkg::CODE_ZERO);
                endcase
            end
            fpcd_pkg::OP_EXIT_PROT:
                stData = 16'((step == 4'h0) ? fpcd_pkg::CODE_EXIT
                                            : fpcd_pkg::CODE_ZERO); // see R3
            fpcd_pkg::OP_READ: begin
                // Register, password and bit status reads alike
                stRead = 1'b1; // see R6
                stLast = 1'b1;
                stAddr = cmdAddr; // see R10
            end
            fpcd_pkg::OP_CLR_ALL_NV: begin
                // Flash refuses this while the lock bit is 0
                stData = 16'((step == 4'h0) ? fpcd_pkg::CODE_ERASE
                                            : fpcd_pkg::CODE_CONFIRM);
            end // see R17 R16
            fpcd_pkg::OP_UNLOCK_PWD: begin
                stLast = step == pwdParts + 4'h2; // see R13
                if (step == 4'h0) begin
                    stData = 16'(fpcd_pkg::CODE_UNLK1);
                end else if (step == 4'h1) begin
                    stData = 16'(fpcd_pkg::CODE_UNLK2);
                end else if (stLast) begin
                    stData = 16'(fpcd_pkg::CODE_UNLK3);
                end else begin
                    stAddr = fpcd_pkg::ADDR_W'(pwdIdx);
                    stData = x16 ? password[{pwdIdx[1:0], 4'h0} +: 16]
                                 : 16'(password[{pwdIdx, 3'h0} +: 8]);
                end
            end
            default: begin
                // Two-cycle program forms: X/A0 then second cycle
                if (step == 4'h0) begin
                    stData = 16'(fpcd_pkg::CODE_PROG);
                end else begin
                    case (op)
                        fpcd_pkg::OP_PROG_LOCKREG:
                            stData = cmdData; // see R7
                        fpcd_pkg::OP_PROG_PWD: begin
                            stAddr = cmdAddr; // see R8 R9
                            stData = cmdData;
                        end
                        fpcd_pkg::OP_PROG_BIT: begin
                            stAddr = cmdAddr;
                            stData = 16'(fpcd_pkg::CODE_ZERO); // see R11 R15
                        end
                        fpcd_pkg::OP_CLR_VOLBIT: begin
                            stAddr = cmdAddr;
                            stData = 16'(fpcd_pkg::CODE_ONE); // see R11 R15
                        end
                        default:
                            stData = 16'(fpcd_pkg::CODE_ZERO); // see R12
                    endcase
                end
            end
        endcase
    end

    assign cyc.req    = state == fpcd_pkg::SQ_RUN;
    assign cyc.isRead = stRead;
    assign cyc.addr   = stAddr;
    assign cyc.wdata  = stData;

    ////////////////////////////////////////////////////////////////////////
    fpcd_bus_cycle u_cycle (
        .clk        (clk),
        .rst_n      (rst_n),
        .cyc        (cyc.engine),
        .flashAddr  (flashAddr),
        .flashCeN   (flashCeN),
        .flashOeN   (flashOeN),
        .flashWeN   (flashWeN),
        .flashDqOut (flashDqOut),
        .flashDqOe  (flashDqOe),
        .flashDqIn  (flashDqIn)
    );

endmodule

/* File: test/fpcd_props.sv */
// Pin timing checks for the protection controller
`timescale 1ns/100ps
module fpcd_props (
    input wire logic clk, rst_n, flashCeN, flashOeN, flashWeN, flashDqOe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_strobe_excl: assert property (
        flashWeN || flashOeN) else $error("both strobes low");
    a_write_frame: assert property (
        !flashWeN |-> !flashCeN && flashDqOe) else $error("bad write");
    a_read_float: assert property (
        !flashOeN |-> !flashCeN && !flashDqOe) else $error("bad read");
    a_write_pulse: assert property (
        $fell(flashWeN) |-> !flashWeN [*8] ##1 flashWeN) else $error("we");
    a_read_pulse: assert property (
        $fell(flashOeN) |-> !flashOeN [*8] ##1 flashOeN) else $error("oe");
    a_frame_setup: assert property (
        $fell(flashCeN) |-> (flashWeN && flashOeN) [*2]
        ##1 !(flashWeN && flashOeN)) else $error("setup");
    a_frame_recover: assert property (
        $rose(flashWeN) || $rose(flashOeN) |-> !flashCeN [*2] ##1 flashCeN)
        else $error("recovery");
    a_bus_release: assert property (
        flashCeN |-> !flashDqOe) else $error("driving while deselected");
endmodule
bind fpcd_host fpcd_props u_props (.clk, .rst_n, .flashCeN, .flashOeN,
    .flashWeN, .flashDqOe);

/* File: test/fpcd_flash_model.sv */
// Behavioural flash that logs write cycles and answers read cycles
`timescale 1ns/100ps
module fpcd_flash_model (
    input wire logic clk, flashCeN, flashOeN, flashWeN, flashDqOe,
    input wire logic [fpcd_pkg::ADDR_W-1:0] flashAddr,
    input wire logic [fpcd_pkg::DATA_W-1:0] flashDqOut,
    output logic [fpcd_pkg::DATA_W-1:0] flashDqIn
);
    logic [39:0] lg [256];
    realtime     t [256];
    int          n = 0;
    logic [15:0] idle = 16'h0000;
    // Cycles are latched as the write strobe closes
    always @(posedge flashWeN) begin
        lg[n] = {flashAddr, flashDqOut};
        t[n] = $realtime;
        n++;
    end
    // Released bus flips each cycle so stale data cannot pass
    always @(posedge clk) idle <= ~idle;
    assign flashDqIn = flashDqOe ? flashDqOut : !flashCeN && !flashOeN
        ? flashAddr[15:0] ^ 16'h5A5A : idle;
endmodule

/* File: test/tb.sv */
// APB bench for the protection controller against a flash model
`timescale 1ns/100ps
module tb;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready;
    logic pslverr, flashCeN, flashOeN, flashWeN, flashDqOe;
    logic [7:0] paddr = 8'h00, code [6] = '{8'h40, 8'h60, 8'hC0, 8'h50,
        8'hE0, 8'h88};
    logic [23:0] flashAddr, tab [6] = '{24'h8000C3, 24'h9300C3, 24'hB30000,
        24'hC30001, 24'hD00030, 24'hE00000};
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [15:0] flashDqOut, flashDqIn;
    logic [63:0] pw = 64'hFEDCBA9876543210;
    int n_errors = 0, checked = 0, cyc = 0, b, p, e;
    always #5 clk = ~clk;
    fpcd_host uut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .flashAddr, .flashCeN, .flashOeN,
        .flashWeN, .flashDqOut, .flashDqOe, .flashDqIn);
    fpcd_flash_model m (.clk, .flashCeN, .flashOeN, .flashWeN, .flashDqOe,
        .flashAddr, .flashDqOut, .flashDqIn);
    task results();
        if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task ck(logic [39:0] g, logic [39:0] x);
        checked++;
        if (g !== x) $display("ERROR %0t got %h exp %h", $time, g, x);
        if (g !== x) n_errors++;
    endtask
    task apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Polls busy rather than assuming a frame count
    task op(logic [3:0] o);
        b = m.n;
        apb(1'b1, 8'h00, {28'h0, o});
        do apb(1'b0, 8'h14, 32'h0); while (r[0] !== 1'b0);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b1, 8'h0C, pw[31:0]);
        apb(1'b1, 8'h10, pw[63:32]);
        for (int x = 0; x < 2; x++) begin
            apb(1'b1, 8'h1C, 32'(x));
            for (int k = 0; k < 6; k++) begin
                op(4'(k));
                ck(m.lg[b], x ? 40'h55500AA : 40'hAAA00AA);
                ck(m.lg[b + 1], x ? 40'h2AA0055 : 40'h5550055);
                ck(m.lg[b + 2], {x ? 24'h555 : 24'hAAA, 8'h0, code[k]});
                ck(40'(r[6:4]), 40'(k + 1));
                op(4'h6);
                ck({8'h0, m.lg[b][15:0], m.lg[b + 1][15:0]}, 40'h900000);
            end
            op(4'hF);
            p = x ? 4 : 8;
            ck({m.lg[b][7:0], m.lg[b + 1][7:0], m.lg[b + p + 2][7:0],
                16'(m.n - b)}, {24'h250329, 16'(p + 3)});
            for (int i = 0; i < p; i++)
                ck(m.lg[b + i + 2], {24'(i), x ? pw[16*i +: 16]
                    : {8'h0, pw[8*i +: 8]}});
        end
        op(4'hF);
        ck(40'(m.t[b] - m.t[b - 1] >= 1000.0), 40'h1);
        op(4'h5);
        op(4'h7);
        ck({m.lg[b + 2][23:0], m.lg[b + 3][15:0]}, 40'h5500900000);
        ck(40'(r[6:4]), 40'h0);
        // A second command while busy must be dropped and flagged
        apb(1'b1, 8'h00, 32'h6);
        op(4'h6);
        ck(40'(m.n - b), 40'h2);
        ck(40'(r[1]), 40'h1);
        apb(1'b1, 8'h14, 32'h2);
        apb(1'b0, 8'h14, 32'h0);
        ck(40'(r[1]), 40'h0);
        apb(1'b0, 8'h20, 32'h0);
        ck({8'(e), r}, 40'h0100000000);
        apb(1'b1, 8'h04, 32'h3);
        apb(1'b1, 8'h08, 32'hC3);
        for (int k = 0; k < 6; k++) begin
            op(tab[k][23:20]);
            ck({m.lg[b][15:0], m.lg[b + 1][23:0]}, {k == 4 ? 16'h80 : 16'hA0,
                4'h0, tab[k][19:0]});
        end
        op(4'hA);
        apb(1'b0, 8'h18, 32'h0);
        ck({8'(m.n - b), r}, 40'h5A59);
        results();
    end
    always @(posedge clk) begin
        if (++cyc > 30000) n_errors++;
        if (cyc > 30000) results();
    end
endmodule
